/* File: bus_status_grant.sv */
// Purpose: Bus-state sequencer that drives the cycle status code and hands the bus over.
// Assumes: The core asks for cycles on cycle_req from the same clock; ready is a pin.
// Notes:   Each T-state lasts two clocks; status changes at the start of the high half.
// What this block does
// - Status goes passive in third state or wait.
// - Leave passive during fourth state to start.
// - Status floats high during a grant.
// - Release bus only at cycle end.
// - First handover line beats the second.
// - Handover lines idle high on their own.
// - Passive status is all ones.
`timescale 1ns/1ns
`default_nettype none

module bus_status_grant (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Core cycle requests
    input  wire logic       cycle_req,
    input  wire logic [2:0] cycle_type,
    output var  logic       cycle_ack,
    output var  logic       cycle_done,
    output var  logic       bus_granted,
    // Ready pin
    input  wire logic       ready_in,
    // Status pins
    output var  logic       cycle_type_bit_hi_out,
    output var  logic       cycle_type_bit_hi_oe,
    output var  logic       cycle_type_bit_mid_out,
    output var  logic       cycle_type_bit_mid_oe,
    output var  logic       cycle_type_bit_lo_out,
    output var  logic       cycle_type_bit_lo_oe,
    // First handover line
    input  wire logic       bus_handover_line_first_in,
    output var  logic       bus_handover_line_first_out,
    output var  logic       bus_handover_line_first_oe,
    output var  logic       bus_handover_line_first_keep,
    // Second handover line
    input  wire logic       bus_handover_line_second_in,
    output var  logic       bus_handover_line_second_out,
    output var  logic       bus_handover_line_second_oe,
    output var  logic       bus_handover_line_second_keep
);

    bus_status_pkg::bus_state_t state_q;   // Current T-state.
    logic                       phase_q;   // Half of the T-state.
    logic [2:0]                 status_q;  // Status code on the pins.
    logic                       stat_oe_q; // Status pins driven.
    logic                       start_q;   // A cycle was accepted in this fourth state.
    logic                       ended_q;   // Ready seen; cycle ends with this state.
    logic [1:0]                 pend_q;    // Requests waiting for the bus.
    logic                       owner_q;   // Line holding the bus: 0 first, 1 second.
    logic                       rdy1_q;    // Ready synchroniser, first stage.
    logic                       rdy2_q;    // Ready synchroniser, second stage.
    logic                       at_end;    // Last clock of a T-state.
    logic                       at_mid;    // Last clock of the low half.
    logic                       grant_go;  // Take the bus over this clock.
    logic                       grant_sel; // Line picked for the grant.
    logic                       release_hit; // Owner pulsed to hand the bus back.
    logic                       accept;    // Cycle accepted this clock.
    logic                       finish;    // Status returns to passive this clock.

    // Ready matters only in the states where a cycle may end.
    function automatic logic ready_window(input bus_status_pkg::bus_state_t st);
        return (st == bus_status_pkg::ST_THIRD) || (st == bus_status_pkg::ST_WAIT);
    endfunction : ready_window

    handover_if hs_first ();
    handover_if hs_second ();
    // One front end per handover line.
    handover_pin u_first (
        .clk      (clk),
        .rst_n    (rst_n),
        .line_in  (bus_handover_line_first_in),
        .line_out (bus_handover_line_first_out),
        .line_oe  (bus_handover_line_first_oe),
        .keep_hi  (bus_handover_line_first_keep),
        .hs       (hs_first)
    );
    handover_pin u_second (
        .clk      (clk),
        .rst_n    (rst_n),
        .line_in  (bus_handover_line_second_in),
        .line_out (bus_handover_line_second_out),
        .line_oe  (bus_handover_line_second_oe),
        .keep_hi  (bus_handover_line_second_keep),
        .hs       (hs_second)
    );

    // =====================================================================
    // Ready synchroniser and phase
    // =====================================================================
    // Ready comes from a pin, so it passes two flops before use.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy1_q <= 1'h0;
            rdy2_q <= 1'h0;
        end else begin
            rdy1_q <= ready_in;
            rdy2_q <= rdy1_q;
        end
    end

    // The phase toggles every clock; two clocks make one T-state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= bus_status_pkg::PHASE_LOW;
        end else begin
            phase_q <= !phase_q;
        end
    end

    assign at_end = (phase_q == bus_status_pkg::PHASE_HIGH);
    assign at_mid = (phase_q == bus_status_pkg::PHASE_LOW);

    // =====================================================================
    // Decisions
    // =====================================================================
    // first line priority
    assign grant_sel = !pend_q[0];

    // release at cycle end
    // Grants are taken only between cycles, never inside one.
    assign grant_go = at_end && (pend_q != 2'h0) &&
                      ((state_q == bus_status_pkg::ST_IDLE) ||
                       ((state_q == bus_status_pkg::ST_FOURTH) && !start_q));

    // A pending grant blocks new cycles, so a busy core cannot starve masters.
    assign accept = at_mid && (state_q == bus_status_pkg::ST_FOURTH) &&
                    cycle_req && (pend_q == 2'h0);

    assign finish = at_mid && rdy2_q && !ended_q && ready_window(state_q);

    // The owner's second pulse hands the bus back.
    assign release_hit = (state_q == bus_status_pkg::ST_HOLD) &&
                         (owner_q ? hs_second.req_seen : hs_first.req_seen);

    // =====================================================================
    // Bus-state sequencer
    // =====================================================================
    // States advance on the last clock of each T-state, except HOLD, which leaves on any clock with release_hit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= bus_status_pkg::ST_IDLE;
        end else begin
            case (state_q)
                bus_status_pkg::ST_IDLE: begin
                    if (grant_go) begin
                        state_q <= bus_status_pkg::ST_HOLD;
                    end else if (at_end && cycle_req) begin
                        state_q <= bus_status_pkg::ST_FOURTH;
                    end
                end
                bus_status_pkg::ST_T1: begin
                    if (at_end) begin
                        state_q <= bus_status_pkg::ST_T2;
                    end
                end
                bus_status_pkg::ST_T2: begin
                    if (at_end) begin
                        state_q <= bus_status_pkg::ST_THIRD;
                    end
                end
                bus_status_pkg::ST_THIRD, bus_status_pkg::ST_WAIT: begin
                    if (at_end) begin
                        state_q <= ended_q ? bus_status_pkg::ST_FOURTH : bus_status_pkg::ST_WAIT;
                    end
                end
                bus_status_pkg::ST_FOURTH: begin
                    if (at_end) begin
                        if (start_q) begin
                            state_q <= bus_status_pkg::ST_T1;
                        end else if (grant_go) begin
                            state_q <= bus_status_pkg::ST_HOLD;
                        end else begin
                            state_q <= bus_status_pkg::ST_IDLE;
                        end
                    end
                end
                bus_status_pkg::ST_HOLD: begin
                    if (release_hit) begin
                        state_q <= bus_status_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= bus_status_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Cycle start and end markers; start clears as each T-state closes, end only as a T-state outside third or wait closes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'h0;
            ended_q <= 1'h0;
        end else begin
            if (accept) begin
                start_q <= 1'h1;
            end else if (at_end) begin
                start_q <= 1'h0;
            end
            if (finish) begin
                ended_q <= 1'h1;
            end else if (at_end && !ready_window(state_q)) begin
                ended_q <= 1'h0;
            end
        end
    end

    // =====================================================================
    // Status code
    // =====================================================================
    // passive all ones
    // active from fourth state
    // Loaded as the fourth state turns high; held until the cycle ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= bus_status_pkg::CODE_PASSIVE;
        end else if (accept) begin
            status_q <= cycle_type;
        end else if (finish || grant_go) begin
            status_q <= bus_status_pkg::CODE_PASSIVE;
        end
    end

    // float during grant
    // Pins float while another master owns the bus; the keeper reads as one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_oe_q <= 1'h1;
        end else if (grant_go) begin
            stat_oe_q <= 1'h0;
        end else if (release_hit) begin
            stat_oe_q <= 1'h1;
        end
    end

    assign cycle_type_bit_hi_out  = status_q[2];
    assign cycle_type_bit_mid_out = status_q[1];
    assign cycle_type_bit_lo_out  = status_q[0];
    assign cycle_type_bit_hi_oe   = stat_oe_q;
    assign cycle_type_bit_mid_oe  = stat_oe_q;
    assign cycle_type_bit_lo_oe   = stat_oe_q;

    // =====================================================================
    // Requests and grants
    // =====================================================================
    // A request on a line in the same clock as that line's grant clear is dropped, since the grant blanks req_seen.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 2'h0;
        end else begin
            pend_q[0] <= (hs_first.req_seen && !(release_hit && !owner_q)) ||
                         (pend_q[0] && !(grant_go && !grant_sel));
            pend_q[1] <= (hs_second.req_seen && !(release_hit && owner_q)) ||
                         (pend_q[1] && !(grant_go && grant_sel));
        end
    end

    // Remember which line holds the bus.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owner_q <= 1'h0;
        end else if (grant_go) begin
            owner_q <= grant_sel;
        end
    end

    assign hs_first.grant  = grant_go && !grant_sel;
    assign hs_second.grant = grant_go && grant_sel;

    // Acknowledge and done to the core are registered one-clock pulses.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_ack   <= 1'h0;
            cycle_done  <= 1'h0;
            bus_granted <= 1'h0;
        end else begin
            cycle_ack   <= accept;
            cycle_done  <= finish;
            bus_granted <= (grant_go || bus_granted) && !release_hit;
        end
    end

endmodule : bus_status_grant

`default_nettype wire

/* File: bus_status_pkg.sv */
// Purpose: Shared constants and types for the bus-cycle status and bus handover block.
// Assumes: One system clock at 250 MHz; each bus T-state spans two clock cycles.
// Notes:   Status codes are read with the high bit first.
package bus_status_pkg;

    // =====================================================================
    // Status codes
    // =====================================================================
    localparam logic [2:0] CODE_INT_ACK   = 3'h0;  // Interrupt acknowledge.
    localparam logic [2:0] CODE_IO_READ   = 3'h1;  // I/O read.
    localparam logic [2:0] CODE_IO_WRITE  = 3'h2;  // I/O write.
    localparam logic [2:0] CODE_HALT      = 3'h3;  // Halt.
    localparam logic [2:0] CODE_FETCH     = 3'h4;  // Code fetch.
    localparam logic [2:0] CODE_MEM_READ  = 3'h5;  // Memory read.
    localparam logic [2:0] CODE_MEM_WRITE = 3'h6;  // Memory write.
    localparam logic [2:0] CODE_PASSIVE   = 3'h7;  // Passive, no cycle.

    // =====================================================================
    // Timing
    // =====================================================================
    localparam logic PHASE_LOW  = 1'h0;             // First half of a T-state.
    localparam logic PHASE_HIGH = 1'h1;             // Second half of a T-state.
    localparam logic [1:0] ECHO_MASK_CYCLES = 2'h3; // Own grant echo blanking.

    // =====================================================================
    // Bus states
    // =====================================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_THIRD,
        ST_WAIT,
        ST_FOURTH,
        ST_HOLD
    } bus_state_t;

endpackage : bus_status_pkg

/* File: handover_if.sv */
// Purpose: Carries request and grant events between the sequencer and one handover pin.
// Assumes: Both sides run on the same clock.
// Notes:   All signals are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

interface handover_if;
    logic req_seen;  // Pulse: a low request pulse was seen on the line.
    logic grant;     // Pulse: drive one grant pulse onto the line.

    // Pin side and sequencer side views.
    modport pin (output req_seen, input grant);
    modport seq (input req_seen, output grant);
endinterface : handover_if

`default_nettype wire

/* File: handover_pin.sv */
// Purpose: Front end of one request/grant line: synchroniser, pulse detect, grant drive.
// Assumes: The far master drives low pulses one clock wide; the line idles high.
// Notes:   The keeper output models the bus-hold that holds an open line high.
`timescale 1ns/1ns
`default_nettype none

module handover_pin (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin
    input  wire logic line_in,
    output var  logic line_out,
    output var  logic line_oe,
    output var  logic keep_hi,
    // Sequencer side
    handover_if.pin   hs
);

    // =====================================================================
    // Synchroniser and edge detect
    // =====================================================================
    logic       sync1_q;   // First stage, read only by the second.
    logic       sync2_q;   // Second stage.
    logic       prev_q;    // Previous synchronised level.
    logic [1:0] mask_q;    // Blanks detection while our own pulse echoes.

    // Reset to high so a floating line never looks like a request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'h1;
            sync2_q <= 1'h1;
            prev_q  <= 1'h1;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Count down after each grant so our own low is not taken as a request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 2'h0;
        end else if (hs.grant) begin
            mask_q <= bus_status_pkg::ECHO_MASK_CYCLES;
        end else if (mask_q != 2'h0) begin
            mask_q <= mask_q - 2'h1;
        end
    end

    // one-clock low pulse
    // A falling edge marks the start of a request pulse.
    assign hs.req_seen = prev_q && !sync2_q && (mask_q == 2'h0) && !hs.grant;

    // =====================================================================
    // Grant drive
    // =====================================================================
    // idle high keeper
    // The keeper stays on except while we pull the line low ourselves.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_oe  <= 1'h0;
            line_out <= 1'h1;
            keep_hi  <= 1'h1;
        end else begin
            line_oe  <= hs.grant;
            line_out <= !hs.grant;
            keep_hi  <= !hs.grant;
        end
    end

endmodule : handover_pin

`default_nettype wire

/* File: bus_status_grant_properties.sv */
// Purpose: Concurrent checks on the status and handover ports of the sequencer.
// Assumes: One clock domain; rst_n is asynchronous and active low.
// Notes:   Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none

module bus_status_grant_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Core side
    input wire logic       cycle_req,
    input wire logic [2:0] cycle_type,
    input wire logic       cycle_ack,
    input wire logic       cycle_done,
    input wire logic       bus_granted,
    input wire logic       ready_in,
    // Status pins
    input wire logic       cycle_type_bit_hi_out,
    input wire logic       cycle_type_bit_hi_oe,
    input wire logic       cycle_type_bit_mid_out,
    input wire logic       cycle_type_bit_mid_oe,
    input wire logic       cycle_type_bit_lo_out,
    input wire logic       cycle_type_bit_lo_oe,
    // Handover lines
    input wire logic       bus_handover_line_first_in,
    input wire logic       bus_handover_line_first_out,
    input wire logic       bus_handover_line_first_oe,
    input wire logic       bus_handover_line_first_keep,
    input wire logic       bus_handover_line_second_in,
    input wire logic       bus_handover_line_second_out,
    input wire logic       bus_handover_line_second_oe,
    input wire logic       bus_handover_line_second_keep
);
    logic [2:0] code;   // Driven status code, high bit first.
    logic       grant;  // A grant pulse on either line.
    logic       flt;    // Some status bit is floated.
    assign code  = {cycle_type_bit_hi_out, cycle_type_bit_mid_out, cycle_type_bit_lo_out};
    assign grant = bus_handover_line_first_oe | bus_handover_line_second_oe;
    assign flt   = ~(cycle_type_bit_hi_oe & cycle_type_bit_mid_oe & cycle_type_bit_lo_oe);

    // =====================================================================
    // Properties
    // =====================================================================
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ack_loads_code: assert property (cycle_ack |-> code == cycle_type)
        else $error("status code differs from the requested type");
    chk_done_passive: assert property (cycle_done |-> code == 3'h7 && $past(code) != 3'h7)
        else $error("cycle end without a fresh return to passive");
    chk_code_holds: assert property (cycle_ack |=> $stable(code) [*5])
        else $error("status code left early in the cycle");
    chk_done_bound: assert property (cycle_ack |-> ##[6:400] cycle_done)
        else $error("cycle never returned to passive");
    chk_grant_pulse: assert property (bus_handover_line_first_oe |->
        !bus_handover_line_first_out ##1 !bus_handover_line_first_oe)
        else $error("first line grant is not a one clock low pulse");
    chk_grant_floats: assert property (grant |-> bus_granted && flt && !cycle_type_bit_hi_oe)
        else $error("status still driven while granting");
    chk_float_high: assert property (flt |-> code == 3'h7)
        else $error("floated status does not read as ones");
    chk_grant_at_end: assert property (grant |-> $past(code) == 3'h7 && !cycle_ack)
        else $error("bus handed over inside a cycle");
    chk_one_grant: assert property (!(bus_handover_line_first_oe && bus_handover_line_second_oe))
        else $error("both lines granted at once");
    chk_idle_keep: assert property (!bus_granted && !$past(bus_granted) && !grant
        |-> bus_handover_line_first_keep && bus_handover_line_second_keep)
        else $error("keeper off while the bus is ours");

    cov_cycle: cover property (cycle_ack ##6 cycle_done);
    cov_first: cover property (bus_handover_line_first_oe);
    cov_second: cover property (bus_handover_line_second_oe);
endmodule : bus_status_grant_properties

bind bus_status_grant bus_status_grant_properties u_props (.*);

`default_nettype wire

/* File: handover_master_model.sv */
// Purpose: Another local bus master on one request/grant line, with wire resolution.
// Assumes: The bench pulses fire for one clock to make a request or a release.
// Notes:   While it owns the bus it holds the line high itself.
`timescale 1ns/1ns
`default_nettype none

module handover_master_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench control
    input  wire logic fire,
    // Device pin halves
    input  wire logic dev_out,
    input  wire logic dev_oe,
    input  wire logic dev_keep,
    // Resolved line
    output var  logic line
);
    logic pull_lo_q;  // Driving the low pulse this clock.
    logic owned_q;    // Granted; the line is ours to hold high.
    logic rel_q;      // Release sent, waiting for the keeper to return.
    logic last_q;     // Last resolved level.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pull_lo_q <= 1'h0;
        else pull_lo_q <= fire;
    end

    // Ownership lasts until the device's keeper is back, else the line would float.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owned_q <= 1'h0;
            rel_q   <= 1'h0;
        end else if (dev_oe && !dev_out) begin
            owned_q <= 1'h1;
        end else if (owned_q && pull_lo_q) begin
            rel_q <= 1'h1;
        end else if (rel_q && dev_keep) begin
            owned_q <= 1'h0;
            rel_q   <= 1'h0;
        end
    end

    // An undriven line with no keeper shows the inverse of its last level.
    always_ff @(posedge clk) last_q <= line;

    always_comb begin
        if (dev_oe) line = dev_out;
        else if (pull_lo_q) line = 1'h0;
        else if (owned_q || dev_keep) line = 1'h1;
        else line = ~last_q;
    end
endmodule : handover_master_model

`default_nettype wire

/* File: tb_bus_status_grant.sv */
// Purpose: Self-checking bench for the status sequencer and bus handover.
// Assumes: Inputs change 1 ns after the rising edge; seed fixed.
// Notes:   Floated status reads as ones, as the hold-high would make it.
`timescale 1ns/1ns
`default_nettype none

module tb_bus_status_grant;
    logic       clk, rst_n, cycle_req, ready_in, fire1, fire2;
    logic [2:0] cycle_type, s_out, s_oe, pins;
    logic       cycle_ack, cycle_done, bus_granted;
    logic       l1, o1, e1, k1, l2, o2, e2, k2;
    int         n_mismatch, total_checks, n, k;

    assign pins = s_out | ~s_oe;

    bus_status_grant u_bus_status_grant (
        .clk(clk), .rst_n(rst_n), .cycle_req(cycle_req), .cycle_type(cycle_type),
        .cycle_ack(cycle_ack), .cycle_done(cycle_done), .bus_granted(bus_granted),
        .ready_in(ready_in),
        .cycle_type_bit_hi_out(s_out[2]), .cycle_type_bit_hi_oe(s_oe[2]),
        .cycle_type_bit_mid_out(s_out[1]), .cycle_type_bit_mid_oe(s_oe[1]),
        .cycle_type_bit_lo_out(s_out[0]), .cycle_type_bit_lo_oe(s_oe[0]),
        .bus_handover_line_first_in(l1), .bus_handover_line_first_out(o1),
        .bus_handover_line_first_oe(e1), .bus_handover_line_first_keep(k1),
        .bus_handover_line_second_in(l2), .bus_handover_line_second_out(o2),
        .bus_handover_line_second_oe(e2), .bus_handover_line_second_keep(k2));
    handover_master_model u_master_first (.clk(clk), .rst_n(rst_n), .fire(fire1),
        .dev_out(o1), .dev_oe(e1), .dev_keep(k1), .line(l1));
    handover_master_model u_master_second (.clk(clk), .rst_n(rst_n), .fire(fire2),
        .dev_out(o2), .dev_oe(e2), .dev_keep(k2), .line(l2));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    // Selects the awaited output; 4 means the bus came back to us.
    function automatic logic sig(input int sel);
        case (sel)
            0: return cycle_ack === 1'h1;
            1: return cycle_done === 1'h1;
            2: return e1 === 1'h1;
            3: return e2 === 1'h1;
            default: return bus_granted === 1'h0;
        endcase
    endfunction : sig

    // Bounded wait; while waiting for done, no handover may appear.
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        while (!sig(sel) && n < lim) begin
            if (sel == 1) check({e1, e2}, 8'h0);
            tick();
            n++;
        end
        if (n >= lim) begin
            $display("[ERR] %0t wait %0d ran out", $time, sel);
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_on

    // One cycle; ready held low for stall clocks adds wait states when stall is above 3.
    task automatic run_cycle(input logic [2:0] code, input int stall);
        cycle_req  = 1'h1;
        cycle_type = code;
        ready_in   = (stall == 0);
        wait_on(0, 200);
        check(pins, code);
        cycle_req = 1'h0;
        repeat (stall) tick();
        ready_in = 1'h1;
        wait_on(1, 400);
        check(pins, 3'h7);
        check(8'(stall + n == 6 || (stall > 0 && stall + n > 6)), 8'h1);
    endtask : run_cycle

    // Bit 0 fires the first master, bit 1 the second.
    task automatic pulse(input logic [1:0] sel);
        fire1 = sel[0];
        fire2 = sel[1];
        tick();
        fire1 = 1'h0;
        fire2 = 1'h0;
    endtask : pulse

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        {rst_n, cycle_req, fire1, fire2} = 4'h0;
        cycle_type   = 3'h0;
        ready_in     = 1'h1;
        n_mismatch   = 0;
        total_checks = 0;
        n = $urandom(38311);
        repeat (4) @(posedge clk);
        check({s_oe, pins}, 8'h3f);
        #1 rst_n = 1'h1;
        tick();
        check({l1, l2}, 8'h3);
        // Every code but passive once, back to back.
        for (k = 0; k < 7; k++) run_cycle(3'(k), 0);
        // Request mid-cycle: grant only after the end; new cycles held off.
        cycle_req = 1'h1;
        wait_on(0, 200);
        cycle_req = 1'h0;
        pulse(2'h1);
        wait_on(1, 400);
        wait_on(2, 100);
        check({pins, s_oe, bus_granted}, 8'h71);
        cycle_req = 1'h1;
        for (k = 0; k < 8; k++) begin
            tick();
            check(cycle_ack, 1'h0);
        end
        pulse(2'h1);
        wait_on(4, 100);
        wait_on(0, 200);
        cycle_req = 1'h0;
        wait_on(1, 400);
        // Both at once: first wins, second follows the release.
        pulse(2'h3);
        wait_on(2, 100);
        check(e2, 1'h0);
        repeat (6) tick();
        pulse(2'h1);
        wait_on(3, 100);
        check({e1, bus_granted}, 8'h1);
        repeat (6) tick();
        pulse(2'h2);
        wait_on(4, 100);
        // Random codes and wait states.
        for (k = 0; k < 24; k++) begin
            run_cycle(3'($urandom_range(6, 0)), ($urandom_range(3, 0) == 0) ? 0 : $urandom_range(6, 1));
        end
        report_and_stop();
    end
endmodule : tb_bus_status_grant

`default_nettype wire
